// [perf_sel_pkg.sv]
package perf_sel_pkg;

    // ==========================================================
    // control register fields
    localparam int EVT_SEL_HI = 31;
    localparam int EVT_SEL_LO = 25;
    localparam int EVT_MASK_HI = 24;
    localparam int EVT_MASK_LO = 9;
    localparam int EVT_SEL_W = EVT_SEL_HI - EVT_SEL_LO + 1;
    localparam int EVT_MASK_W = EVT_MASK_HI - EVT_MASK_LO + 1;
    localparam int CFG_SEL_W = 3;
    localparam int NUM_COUNTERS = 12;

    // ==========================================================
    // event select codes
    localparam logic [6:0] SEL_FETCH_REQ = 7'h03;
    localparam logic [6:0] SEL_XLATE_LOOKUP = 7'h18;
    localparam logic [6:0] SEL_MEM_CANCEL = 7'h02;
    localparam logic [6:0] SEL_MEM_COMPLETE = 7'h08;
    localparam logic [6:0] SEL_LOAD_REPLAY = 7'h04;
    // no second event on this unit; code never matches a valid field
    localparam logic [6:0] SEL_NONE = 7'h7f;

    // ==========================================================
    // counter configuration select codes
    localparam logic [2:0] CFG_FETCH = 3'h0;
    localparam logic [2:0] CFG_XLATE = 3'h3;
    localparam logic [2:0] CFG_CANCEL = 3'h5;
    localparam logic [2:0] CFG_SPLIT = 3'h2;

    // ==========================================================
    // event mask bit positions
    localparam int MB_TRACE_MISS = 0;
    localparam int MB_XLATE_HIT = 0;
    localparam int MB_XLATE_MISS = 1;
    localparam int MB_UNCACHEABLE_HIT = 2;
    localparam int MB_STORE_BUF_FULL = 2;
    localparam int MB_ALL_CACHE_MISS = 7;
    localparam int MB_LOAD_SPLIT_DONE = 0;
    localparam int MB_STORE_SPLIT_DONE = 1;
    localparam int MB_SPLIT_LOAD = 1;

    // ==========================================================
    // reset values
    localparam logic [NUM_COUNTERS-1:0] INC_RST = 12'h000;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic enable;
        logic [CFG_SEL_W-1:0] sel;
    } counter_cfg_s;

    typedef struct packed {
        logic trace_lookup_miss;
        logic xlate_hit;
        logic xlate_miss;
        logic xlate_uncacheable_hit;
        logic store_buffer_full;
        logic all_cache_miss;
        logic uncacheable_access;
        logic load_split_done;
        logic load_uncacheable_wc;
        logic store_split_done;
        logic split_load_replay;
    } occurrence_s;

    function automatic logic [EVT_SEL_W-1:0] evt_sel(input logic [31:0] ctrl);
        evt_sel = ctrl[EVT_SEL_HI:EVT_SEL_LO];
    endfunction

    function automatic logic [EVT_MASK_W-1:0] evt_mask(input logic [31:0] ctrl);
        evt_mask = ctrl[EVT_MASK_HI:EVT_MASK_LO];
    endfunction

endpackage

// [evt_qual_match.sv]
`timescale 1ns/1ps
`default_nettype none

// one control register: match its event code and any selected qualifier
module evt_qual_match #(
    parameter logic [6:0] CODE_A = 7'h00,
    parameter logic [6:0] CODE_B = 7'h7f
) (
    // control register image
    input wire logic [31:0] i_ctrl,
    // qualifier strobes aligned to mask bits
    input wire logic [15:0] i_qual_a,
    input wire logic [15:0] i_qual_b,
    // result
    output logic o_hit
);
    logic [6:0] sel;
    logic [15:0] mask;
    logic hit_a;
    logic hit_b;

    assign sel = perf_sel_pkg::evt_sel(i_ctrl);
    assign mask = perf_sel_pkg::evt_mask(i_ctrl);
    // any selected qualifier gives a single increment
    assign hit_a = (sel == CODE_A) && |(mask & i_qual_a);
    assign hit_b = (sel == CODE_B) && |(mask & i_qual_b);
    assign o_hit = hit_a | hit_b;
endmodule

`default_nettype wire

// [counter_route.sv]
`timescale 1ns/1ps
`default_nettype none

// one counter: pick which unit feeds it by its configuration select
module counter_route #(
    parameter logic [2:0] CFG_A = 3'h0,
    parameter logic [2:0] CFG_B = 3'h3
) (
    // counter configuration
    input wire perf_sel_pkg::counter_cfg_s i_cfg,
    // matches from the two units wired to this counter
    input wire logic i_hit_a,
    input wire logic i_hit_b,
    // results
    output logic o_inc,
    output logic o_bad_cfg
);
    logic pick_a;
    logic pick_b;

    assign pick_a = i_cfg.sel == CFG_A;
    assign pick_b = i_cfg.sel == CFG_B;
    assign o_inc = i_cfg.enable && ((pick_a && i_hit_a) || (pick_b && i_hit_b));
    // a select naming a unit not wired here never counts
    assign o_bad_cfg = i_cfg.enable && !pick_a && !pick_b;
endmodule

`default_nettype wire

// [perf_event_select_decoder.sv]
`timescale 1ns/1ps
`default_nettype none

module perf_event_select_decoder #(
    parameter int NUM_CTR = perf_sel_pkg::NUM_COUNTERS
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // event select control registers, two per unit
    input wire logic [1:0][31:0] i_fetch_ctrl,
    input wire logic [1:0][31:0] i_xlate_ctrl,
    input wire logic [1:0][31:0] i_cancel_ctrl,
    input wire logic [1:0][31:0] i_split_ctrl,
    // counter configuration control registers
    input wire perf_sel_pkg::counter_cfg_s [NUM_CTR-1:0] i_counter_cfg,
    // occurrence strobes from the pipeline, same clock
    input wire perf_sel_pkg::occurrence_s i_occ,
    // increment pulses and configuration status
    output logic [NUM_CTR-1:0] o_count_inc,
    output logic [NUM_CTR-1:0] o_cfg_error
);

    // ==========================================================
    // qualifier vectors aligned to mask bits
    logic [15:0] q_fetch;
    logic [15:0] q_xlate;
    logic [15:0] q_cancel;
    logic [15:0] q_complete;
    logic [15:0] q_replay;
    logic load_split_clean;

    always_comb begin
        q_fetch = 16'h0000;
        q_fetch[perf_sel_pkg::MB_TRACE_MISS] = i_occ.trace_lookup_miss;
    end

    // page size is not seen here: each reference is one small-page lookup
    always_comb begin
        q_xlate = 16'h0000;
        q_xlate[perf_sel_pkg::MB_XLATE_HIT] = i_occ.xlate_hit;
        q_xlate[perf_sel_pkg::MB_XLATE_MISS] = i_occ.xlate_miss;
        q_xlate[perf_sel_pkg::MB_UNCACHEABLE_HIT] = i_occ.xlate_uncacheable_hit;
    end

    always_comb begin
        q_cancel = 16'h0000;
        q_cancel[perf_sel_pkg::MB_STORE_BUF_FULL] = i_occ.store_buffer_full;
        // uncacheable memory never hits, so it joins the miss count
        q_cancel[perf_sel_pkg::MB_ALL_CACHE_MISS] =
            i_occ.all_cache_miss | i_occ.uncacheable_access;
    end

    assign load_split_clean = i_occ.load_split_done && !i_occ.load_uncacheable_wc;

    always_comb begin
        q_complete = 16'h0000;
        q_complete[perf_sel_pkg::MB_LOAD_SPLIT_DONE] = load_split_clean;
        q_complete[perf_sel_pkg::MB_STORE_SPLIT_DONE] = i_occ.store_split_done;
    end

    always_comb begin
        q_replay = 16'h0000;
        q_replay[perf_sel_pkg::MB_SPLIT_LOAD] = i_occ.split_load_replay;
    end

    // ==========================================================
    // per control register event match
    logic [1:0] hit_fetch;
    logic [1:0] hit_xlate;
    logic [1:0] hit_cancel;
    logic [1:0] hit_split;

    for (genvar e = 0; e < 2; e++) begin : g_ctrl
        evt_qual_match #(
            .CODE_A(perf_sel_pkg::SEL_FETCH_REQ),
            .CODE_B(perf_sel_pkg::SEL_NONE)
        ) u_fetch (
            .i_ctrl(i_fetch_ctrl[e]),
            .i_qual_a(q_fetch),
            .i_qual_b(16'h0000),
            .o_hit(hit_fetch[e])
        );

        evt_qual_match #(
            .CODE_A(perf_sel_pkg::SEL_XLATE_LOOKUP),
            .CODE_B(perf_sel_pkg::SEL_NONE)
        ) u_xlate (
            .i_ctrl(i_xlate_ctrl[e]),
            .i_qual_a(q_xlate),
            .i_qual_b(16'h0000),
            .o_hit(hit_xlate[e])
        );

        evt_qual_match #(
            .CODE_A(perf_sel_pkg::SEL_MEM_CANCEL),
            .CODE_B(perf_sel_pkg::SEL_NONE)
        ) u_cancel (
            .i_ctrl(i_cancel_ctrl[e]),
            .i_qual_a(q_cancel),
            .i_qual_b(16'h0000),
            .o_hit(hit_cancel[e])
        );

        // one register serves completions and replays by its code
        evt_qual_match #(
            .CODE_A(perf_sel_pkg::SEL_MEM_COMPLETE),
            .CODE_B(perf_sel_pkg::SEL_LOAD_REPLAY)
        ) u_split (
            .i_ctrl(i_split_ctrl[e]),
            .i_qual_a(q_complete),
            .i_qual_b(q_replay),
            .o_hit(hit_split[e])
        );
    end

    // ==========================================================
    // counter routing
    logic [NUM_CTR-1:0] inc_d;
    logic [NUM_CTR-1:0] bad_d;
    logic [NUM_CTR-1:0] inc_q;
    logic [NUM_CTR-1:0] bad_q;

    for (genvar c = 0; c < NUM_CTR; c++) begin : g_ctr
        // counters 0,1 and 8,9 take the first register, 2,3 and 10,11 the second
        localparam int R = (c / 2) % 2;
        if (c < 4) begin : g_front
            counter_route #(
                .CFG_A(perf_sel_pkg::CFG_FETCH),
                .CFG_B(perf_sel_pkg::CFG_XLATE)
            ) u_route (
                .i_cfg(i_counter_cfg[c]),
                .i_hit_a(hit_fetch[R]),
                .i_hit_b(hit_xlate[R]),
                .o_inc(inc_d[c]),
                .o_bad_cfg(bad_d[c])
            );
        end else if (c >= 8) begin : g_mem
            counter_route #(
                .CFG_A(perf_sel_pkg::CFG_CANCEL),
                .CFG_B(perf_sel_pkg::CFG_SPLIT)
            ) u_route (
                .i_cfg(i_counter_cfg[c]),
                .i_hit_a(hit_cancel[R]),
                .i_hit_b(hit_split[R]),
                .o_inc(inc_d[c]),
                .o_bad_cfg(bad_d[c])
            );
        end else begin : g_none
            // counters 4-7 carry none of these events
            assign inc_d[c] = 1'b0;
            assign bad_d[c] = i_counter_cfg[c].enable;
        end
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            inc_q <= perf_sel_pkg::INC_RST;
            bad_q <= perf_sel_pkg::INC_RST;
        end else begin
            inc_q <= inc_d;
            bad_q <= bad_d;
        end
    end

    assign o_count_inc = inc_q;
    assign o_cfg_error = bad_q;

    // ==========================================================
    // checks
    logic f0_armed;
    logic x2_hit_armed;
    logic c8_buf_armed;
    logic c10_miss_armed;
    logic s9_load_armed;
    logic s11_store_armed;
    logic r8_replay_armed;

    assign f0_armed = i_counter_cfg[0].enable
        && i_counter_cfg[0].sel == perf_sel_pkg::CFG_FETCH
        && perf_sel_pkg::evt_sel(i_fetch_ctrl[0]) == perf_sel_pkg::SEL_FETCH_REQ
        && i_fetch_ctrl[0][perf_sel_pkg::EVT_MASK_LO + perf_sel_pkg::MB_TRACE_MISS];
    assign x2_hit_armed = i_counter_cfg[2].enable
        && i_counter_cfg[2].sel == perf_sel_pkg::CFG_XLATE
        && perf_sel_pkg::evt_sel(i_xlate_ctrl[1]) == perf_sel_pkg::SEL_XLATE_LOOKUP
        && i_xlate_ctrl[1][perf_sel_pkg::EVT_MASK_LO + perf_sel_pkg::MB_XLATE_HIT];
    assign c8_buf_armed = i_counter_cfg[8].enable
        && i_counter_cfg[8].sel == perf_sel_pkg::CFG_CANCEL
        && perf_sel_pkg::evt_sel(i_cancel_ctrl[0]) == perf_sel_pkg::SEL_MEM_CANCEL
        && i_cancel_ctrl[0][perf_sel_pkg::EVT_MASK_LO + perf_sel_pkg::MB_STORE_BUF_FULL];
    assign c10_miss_armed = i_counter_cfg[10].enable
        && i_counter_cfg[10].sel == perf_sel_pkg::CFG_CANCEL
        && perf_sel_pkg::evt_sel(i_cancel_ctrl[1]) == perf_sel_pkg::SEL_MEM_CANCEL
        && i_cancel_ctrl[1][perf_sel_pkg::EVT_MASK_LO + perf_sel_pkg::MB_ALL_CACHE_MISS];
    assign s9_load_armed = i_counter_cfg[9].enable
        && i_counter_cfg[9].sel == perf_sel_pkg::CFG_SPLIT
        && perf_sel_pkg::evt_sel(i_split_ctrl[0]) == perf_sel_pkg::SEL_MEM_COMPLETE
        && i_split_ctrl[0][perf_sel_pkg::EVT_MASK_LO + perf_sel_pkg::MB_LOAD_SPLIT_DONE];
    assign s11_store_armed = i_counter_cfg[11].enable
        && i_counter_cfg[11].sel == perf_sel_pkg::CFG_SPLIT
        && perf_sel_pkg::evt_sel(i_split_ctrl[1]) == perf_sel_pkg::SEL_MEM_COMPLETE
        && i_split_ctrl[1][perf_sel_pkg::EVT_MASK_LO + perf_sel_pkg::MB_STORE_SPLIT_DONE];
    assign r8_replay_armed = i_counter_cfg[8].enable
        && i_counter_cfg[8].sel == perf_sel_pkg::CFG_SPLIT
        && perf_sel_pkg::evt_sel(i_split_ctrl[0]) == perf_sel_pkg::SEL_LOAD_REPLAY
        && i_split_ctrl[0][perf_sel_pkg::EVT_MASK_LO + perf_sel_pkg::MB_SPLIT_LOAD];

    sequence s_fetch_miss;
        f0_armed && i_occ.trace_lookup_miss;
    endsequence

    property p_fetch_count;
        @(posedge i_clock) disable iff (i_sys_rst)
        s_fetch_miss |=> o_count_inc[0];
    endproperty
    a_fetch_count: assert property (p_fetch_count) else $error("fetch miss not counted");

    property p_xlate_hit;
        @(posedge i_clock) disable iff (i_sys_rst)
        x2_hit_armed && i_occ.xlate_hit |=> o_count_inc[2]
            && (!o_count_inc[0] || $past(i_counter_cfg[0].enable));
    endproperty
    a_xlate_hit: assert property (p_xlate_hit) else $error("lookup hit misrouted");

    property p_cancel_buf;
        @(posedge i_clock) disable iff (i_sys_rst)
        c8_buf_armed && i_occ.store_buffer_full |=> o_count_inc[8];
    endproperty
    a_cancel_buf: assert property (p_cancel_buf) else $error("buffer full not counted");

    property p_cancel_uc;
        @(posedge i_clock) disable iff (i_sys_rst)
        c10_miss_armed && i_occ.uncacheable_access |=> o_count_inc[10];
    endproperty
    a_cancel_uc: assert property (p_cancel_uc) else $error("uncacheable not counted");

    property p_load_split_excl;
        @(posedge i_clock) disable iff (i_sys_rst)
        s9_load_armed && i_occ.load_split_done && !i_occ.store_split_done
            |=> o_count_inc[9] == !$past(i_occ.load_uncacheable_wc);
    endproperty
    a_load_split_excl: assert property (p_load_split_excl) else $error("load split wrong");

    property p_store_split;
        @(posedge i_clock) disable iff (i_sys_rst)
        s11_store_armed && i_occ.store_split_done |=> o_count_inc[11];
    endproperty
    a_store_split: assert property (p_store_split) else $error("store split missed");

    property p_replay;
        @(posedge i_clock) disable iff (i_sys_rst)
        r8_replay_armed && i_occ.split_load_replay |=> o_count_inc[8];
    endproperty
    a_replay: assert property (p_replay) else $error("split load replay missed");

    property p_idle_counters;
        @(posedge i_clock) disable iff (i_sys_rst)
        o_count_inc[7:4] == 4'h0;
    endproperty
    a_idle_counters: assert property (p_idle_counters) else $error("counter 4-7 pulsed");

    property p_disabled_quiet;
        @(posedge i_clock) disable iff (i_sys_rst)
        !i_counter_cfg[1].enable |=> !o_count_inc[1];
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled counter pulsed");

    sequence s_both_cancel;
        c8_buf_armed && i_occ.store_buffer_full && i_occ.all_cache_miss;
    endsequence

    sequence s_cancel_quiet;
        c8_buf_armed && !i_occ.store_buffer_full && !i_occ.all_cache_miss
            && !i_occ.uncacheable_access;
    endsequence

    // two qualifiers in one cycle must give exactly one pulse, not two
    property p_single_inc;
        @(posedge i_clock) disable iff (i_sys_rst)
        s_both_cancel ##1 s_cancel_quiet |-> o_count_inc[8] ##1 !o_count_inc[8];
    endproperty
    a_single_inc: assert property (p_single_inc) else $error("multi-qual increment wrong");

    property p_mid_cfg_err;
        @(posedge i_clock) disable iff (i_sys_rst)
        i_counter_cfg[5].enable |=> o_cfg_error[5];
    endproperty
    a_mid_cfg_err: assert property (p_mid_cfg_err) else $error("counter 5 enable not flagged");

endmodule

`default_nettype wire

// [occ_source.sv]
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// pipeline strobe source
// fresh random pulses after every rising clock edge out of reset; the bench may pin a pattern instead
module occ_source (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // pinned pattern
    input wire logic i_use_fixed,
    input wire perf_sel_pkg::occurrence_s i_fixed,
    // strobes
    output var perf_sel_pkg::occurrence_s o_occ
);
    perf_sel_pkg::occurrence_s rnd_q;

    // redrawn each cycle, so a strobe stays high only when it is drawn high again
    always @(posedge i_clock or posedge i_sys_rst) begin
        #1;
        rnd_q = i_sys_rst ? 11'h000 : 11'($urandom);
    end

    assign o_occ = i_use_fixed ? i_fixed : rnd_q;
endmodule

`default_nettype wire

// [tb_perf_event_select_decoder.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_perf_event_select_decoder;
    localparam logic [6:0] CODES [7] = '{7'h03, 7'h18, 7'h02, 7'h08, 7'h04, 7'h05, 7'h01};
    localparam logic [2:0] SELS [5] = '{3'h0, 3'h3, 3'h5, 3'h2, 3'h7};
    logic i_clock;
    logic i_sys_rst;
    logic use_fixed;
    logic [1:0][31:0] fetch_ctrl, xlate_ctrl, cancel_ctrl, split_ctrl;
    perf_sel_pkg::counter_cfg_s [11:0] cfg;
    perf_sel_pkg::occurrence_s occ, fixed_occ;
    logic [11:0] o_count_inc, o_cfg_error, exp_inc, exp_err;
    int num_errors = 0;
    int tests_run = 0;
    int seed_dummy;

    // ==========================================================
    // design and strobe source
    perf_event_select_decoder #(.NUM_CTR(12)) perf_event_select_decoder_i (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_fetch_ctrl(fetch_ctrl),
        .i_xlate_ctrl(xlate_ctrl),
        .i_cancel_ctrl(cancel_ctrl),
        .i_split_ctrl(split_ctrl),
        .i_counter_cfg(cfg),
        .i_occ(occ),
        .o_count_inc(o_count_inc),
        .o_cfg_error(o_cfg_error)
    );

    occ_source occ_source_i (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_use_fixed(use_fixed),
        .i_fixed(fixed_occ),
        .o_occ(occ)
    );

    initial begin
        i_clock = 1'b0;
        forever #50 i_clock = ~i_clock;
    end

    // ==========================================================
    // reference model
    function automatic logic unit_hit(input int u, input logic [31:0] c);
        logic [6:0] s;
        logic [15:0] m;
        s = c[31:25];
        m = c[24:9];
        case (u)
            0: unit_hit = s == 7'h03 && m[0] && occ.trace_lookup_miss;
            1: unit_hit = s == 7'h18 && (m[0] && occ.xlate_hit || m[1] && occ.xlate_miss
                || m[2] && occ.xlate_uncacheable_hit);
            2: unit_hit = s == 7'h02 && (m[2] && occ.store_buffer_full
                || m[7] && (occ.all_cache_miss || occ.uncacheable_access));
            default: unit_hit = s == 7'h08 && (m[0] && occ.load_split_done
                && !occ.load_uncacheable_wc || m[1] && occ.store_split_done)
                || s == 7'h04 && m[1] && occ.split_load_replay;
        endcase
    endfunction

    task automatic predict();
        logic ha, hb, ok;
        logic [2:0] s, a, b;
        int r;
        for (int n = 0; n < 12; n++) begin
            r = (n % 4) / 2;
            s = cfg[n].sel;
            ok = n < 4 || n > 7;
            if (n < 4) begin
                a = 3'h0;
                b = 3'h3;
                ha = unit_hit(0, fetch_ctrl[r]);
                hb = unit_hit(1, xlate_ctrl[r]);
            end else begin
                a = 3'h5;
                b = 3'h2;
                ha = unit_hit(2, cancel_ctrl[r]);
                hb = unit_hit(3, split_ctrl[r]);
            end
            exp_inc[n] = cfg[n].enable && ok && (s == a && ha || s == b && hb);
            exp_err[n] = cfg[n].enable && !(ok && (s == a || s == b));
        end
    endtask

    // ==========================================================
    // checking and ending
    task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // entered just after an edge with inputs set; leaves just after the next edge
    task automatic cycle();
        #1 predict();
        @(posedge i_clock);
        #1;
        check("count_inc_low", {8'h00, o_count_inc[3:0]}, {8'h00, exp_inc[3:0]});
        check("count_inc_mid", {8'h00, o_count_inc[7:4]}, {8'h00, exp_inc[7:4]});
        check("count_inc_high", {o_count_inc[11:8], 8'h00}, {exp_inc[11:8], 8'h00});
        check("cfg_error", o_cfg_error, exp_err);
    endtask

    // one unit programmed, all its counters routed to it, pattern pinned
    task automatic corner(input int u, input int r, input logic [6:0] code,
                          input logic [15:0] m, input logic [10:0] o);
        fetch_ctrl = '0;
        xlate_ctrl = '0;
        cancel_ctrl = '0;
        split_ctrl = '0;
        for (int n = 0; n < 12; n++) begin
            cfg[n] = {n < 4 || n > 7, n < 4 ? (u == 1 ? 3'h3 : 3'h0) : (u == 2 ? 3'h5 : 3'h2)};
        end
        case (u)
            0: fetch_ctrl[r] = {code, m, 9'h000};
            1: xlate_ctrl[r] = {code, m, 9'h000};
            2: cancel_ctrl[r] = {code, m, 9'h000};
            default: split_ctrl[r] = {code, m, 9'h000};
        endcase
        use_fixed = 1'b1;
        fixed_occ = o;
        cycle();
    endtask

    function automatic logic [31:0] rnd_ctrl();
        rnd_ctrl = {CODES[$urandom_range(6)], 16'($urandom), 9'($urandom)};
    endfunction

    // ==========================================================
    // main sequence
    initial begin
        seed_dummy = $urandom(75);
        use_fixed = 1'b0;
        fixed_occ = '0;
        fetch_ctrl = '0;
        xlate_ctrl = '0;
        cancel_ctrl = '0;
        split_ctrl = '0;
        cfg = '0;
        i_sys_rst = 1'b1;
        repeat (6) @(posedge i_clock);
        #1;
        i_sys_rst = 1'b0;
        corner(0, 0, 7'h03, 16'h0001, 11'h400);
        corner(0, 0, 7'h03, 16'h0001, 11'h000);
        corner(0, 1, 7'h03, 16'h0000, 11'h400);
        corner(1, 1, 7'h18, 16'h0007, 11'h380);
        for (int i = 0; i < 3; i++) begin
            corner(1, i % 2, 7'h18, 16'h0001 << i, 11'h200 >> i);
        end
        corner(2, 0, 7'h02, 16'h0004, 11'h040);
        corner(2, 1, 7'h02, 16'h0080, 11'h020);
        corner(2, 0, 7'h02, 16'h0080, 11'h010);
        corner(2, 1, 7'h02, 16'h0084, 11'h060);
        corner(2, 0, 7'h02, 16'h0084, 11'h060);
        corner(2, 0, 7'h02, 16'h0084, 11'h000);
        corner(3, 0, 7'h08, 16'h0001, 11'h008);
        corner(3, 1, 7'h08, 16'h0001, 11'h00c);
        corner(3, 0, 7'h08, 16'h0002, 11'h002);
        corner(3, 1, 7'h04, 16'h0002, 11'h001);
        corner(3, 0, 7'h05, 16'hffff, 11'h7ff);
        corner(2, 0, 7'h08, 16'hffff, 11'h7ff);
        use_fixed = 1'b0;
        for (int k = 0; k < 2000; k++) begin
            if (k == 1000) begin
                // reset in mid-run while random traffic is still pulsing
                i_sys_rst = 1'b1;
                #1 check("reset_inc", o_count_inc, 12'h000);
                check("reset_err", o_cfg_error, 12'h000);
                @(posedge i_clock);
                #1 i_sys_rst = 1'b0;
            end
            for (int r = 0; r < 2; r++) begin
                fetch_ctrl[r] = rnd_ctrl();
                xlate_ctrl[r] = rnd_ctrl();
                cancel_ctrl[r] = rnd_ctrl();
                split_ctrl[r] = rnd_ctrl();
            end
            for (int n = 0; n < 12; n++) begin
                cfg[n] = {1'($urandom), SELS[$urandom_range(4)]};
            end
            cycle();
        end
        conclude();
    end

    // about 2030 cycles expected; give a wide margin
    initial begin
        #(100 * 5000);
        num_errors++;
        conclude();
    end
endmodule

`default_nettype wire
